// File: bench/clock_sources_model.sv
`timescale 1ns/1ns
// free-running source oscillators; each phase spans several pclk cycles
module clock_sources_model #(
    parameter int PRIM_HALF = 60,
    parameter int SEC_HALF  = 100,
    parameter int FAST_HALF = 40,
    parameter int SLOW_HALF = 150
) (
    output logic primary_clk_in,
    output logic secondary_clk_in,
    output logic fast_osc_in,
    output logic slow_rc_in
);
    // odd start offsets keep the sources out of phase with pclk and each other
    initial begin
        primary_clk_in = 1'b0;
        #7;
        forever #PRIM_HALF primary_clk_in = ~primary_clk_in;
    end
    // secondary runs from time zero, so it is stable long before any switch
    initial begin
        secondary_clk_in = 1'b0;
        #13;
        forever #SEC_HALF secondary_clk_in = ~secondary_clk_in;
    end
    initial begin
        fast_osc_in = 1'b0;
        #3;
        forever #FAST_HALF fast_osc_in = ~fast_osc_in;
    end
    initial begin
        slow_rc_in = 1'b0;
        #21;
        forever #SLOW_HALF slow_rc_in = ~slow_rc_in;
    end
endmodule : clock_sources_model

// File: bench/tb.sv
`timescale 1ns/1ns
`define CHK(nm, e, g) begin check_count++; if ((e) !== (g)) begin fails++; \
    $display("[ERR] %s exp %0h got %0h", nm, e, g); end end
module tb;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic        power_down_req = 0, ost_expired_in = 0;
    logic [15:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    logic [3:0]  pstrb = 0;
    logic        pready, pslverr, enter_idle, enter_sleep, device_clk, clk_switching;
    logic        prim_c, sec_c, fast_c, slow_c, er, low_ok, idl;
    int          fails = 0, check_count = 0, seed = 39236, t, n;
    time         t0;

    always #5 pclk = ~pclk;

    clock_sources_model src (.primary_clk_in(prim_c), .secondary_clk_in(sec_c),
        .fast_osc_in(fast_c), .slow_rc_in(slow_c));

    system_clock_select_control dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .primary_clk_in(prim_c), .secondary_clk_in(sec_c), .fast_osc_in(fast_c),
        .slow_rc_in(slow_c), .ost_expired_in(ost_expired_in),
        .power_down_req(power_down_req), .enter_idle(enter_idle),
        .enter_sleep(enter_sleep), .device_clk(device_clk),
        .clk_switching(clk_switching));

    task automatic stop_test;
        $display("fails %0d check_count %0d", fails, check_count);
        if (fails == 0 && check_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : stop_test

    // one apb transfer; request held until pready is seen at an edge
    task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d,
                       input logic [3:0] s);
        int k;
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d; pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin @(posedge pclk); k++; end while (pready !== 1'b1 && k < 50);
        if (k >= 50) begin fails++; stop_test(); end
        rd = prdata; er = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask : apb

    // waits for a 0 to 1 step of device_clk as sampled by pclk
    task automatic rise;
        int k;
        logic pv;
        k = 0;
        pv = device_clk;
        @(posedge pclk);
        while (!(pv === 1'b0 && device_clk === 1'b1) && k < 30000) begin
            pv = device_clk; @(posedge pclk); k++;
        end
        if (k >= 30000) fails++;
    endtask : rise

    // settle past any switch, then time one full device_clk period
    task automatic per(input int e);
        n = 0;
        do begin @(posedge pclk); n++; end while (clk_switching !== 1'b0 && n < 3000);
        rise(); rise(); t0 = $time; rise(); t = $time - t0;
        `CHK("period_ok", 1'b1, (t >= e - 20 && t <= e + 20))
    endtask : per

    // fast osc period 80 ns, slow rc 300 ns
    function automatic int exp_per(input logic [2:0] f, input logic l);
        if (f == 3'h7) return 80;
        if (f != 3'h0) return 80 << (7 - f);
        return l ? 80 * 256 : 300;
    endfunction : exp_per

    function automatic logic [31:0] ctl(input logic i, input logic [2:0] f,
                                        input logic o, input logic [1:0] s);
        return {24'h0000_00, i, f, o, 1'b1, s};
    endfunction : ctl

    initial begin
        #900000;
        fails++;
        stop_test();
    end

    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, clock_select_pkg::ADDR_OSC_CTRL, 0, 0);
        `CHK("ctrl_rst", ctl(1'b0, 3'h6, 1'b0, 2'h0), rd)
        ost_expired_in <= 1'b1;
        repeat (8) @(posedge pclk);
        apb(1, clock_select_pkg::ADDR_OSC_CTRL, 32'h0000_0000, 4'h1);
        apb(1, clock_select_pkg::ADDR_OSC_CTRL, 32'h0000_00ff, 4'h0);
        apb(0, clock_select_pkg::ADDR_OSC_CTRL, 0, 0);
        `CHK("ctrl_ost", ctl(1'b0, 3'h0, 1'b1, 2'h0), rd)
        apb(1, 16'h0100, 32'h0000_00ff, 4'hf);
        `CHK("slverr_w", 1'b1, er)
        apb(0, 16'h0100, 0, 0);
        `CHK("slverr_r", {1'b1, 32'h0000_0000}, {er, rd})
        // power-down request in both modes
        for (int i = 0; i < 2; i++) begin
            apb(1, clock_select_pkg::ADDR_OSC_CTRL, ctl(i[0], 3'h6, 1'b0, 2'h0), 4'h1);
            @(posedge pclk) power_down_req <= 1'b1;
            @(posedge pclk) power_down_req <= 1'b0;
            #1;
            `CHK("pd_mode", {i[0], !i[0]}, {enter_idle, enter_sleep})
            @(posedge pclk);
            #1;
            `CHK("pd_pulse", 2'b00, {enter_idle, enter_sleep})
        end
        // internal postscaler ratios, low setting from both sources, random idle bit
        for (int j = 0; j < 9; j++) begin
            idl = $random(seed);
            apb(1, clock_select_pkg::ADDR_OSC_TUNE, {24'h0, (j == 1), 7'h00}, 4'h1);
            apb(1, clock_select_pkg::ADDR_OSC_CTRL,
                ctl(idl, (j < 2) ? 3'h0 : j - 1, 1'b0, 2'h3), 4'h1);
            apb(0, clock_select_pkg::ADDR_OSC_CTRL, 0, 0);
            `CHK("ctrl_ifs", ctl(idl, (j < 2) ? 3'h0 : j - 1, 1'b1, 2'h3), rd)
            per(exp_per((j < 2) ? 3'h0 : j - 1, j == 1));
        end
        // primary source from postscaler or primary input; only the direct 111
        // setting (80 ns period) is used while the internal oscillator could feed the pll
        for (int k = 0; k < 3; k++) begin
            apb(1, clock_select_pkg::ADDR_CFG, 32'h0000_0020 | (k << 2), 4'h1);
            apb(1, clock_select_pkg::ADDR_OSC_CTRL, ctl(1'b0, 3'h7, 1'b0, 2'h0), 4'h1);
            per((k < 2) ? 80 : 120);
        end
        apb(1, clock_select_pkg::ADDR_CFG, 32'h0000_0020, 4'h1);
        apb(1, clock_select_pkg::ADDR_OSC_CTRL, ctl(1'b0, 3'h7, 1'b0, 2'h3), 4'h1);
        per(80);
        // secondary refused while disabled, reserved code refused
        apb(1, clock_select_pkg::ADDR_OSC_CTRL, ctl(1'b0, 3'h5, 1'b0, 2'h1), 4'h1);
        apb(0, clock_select_pkg::ADDR_OSC_CTRL, 0, 0);
        `CHK("sec_refused", ctl(1'b0, 3'h5, 1'b1, 2'h3), rd)
        apb(1, clock_select_pkg::ADDR_OSC_CTRL, ctl(1'b0, 3'h7, 1'b0, 2'h2), 4'h1);
        apb(0, clock_select_pkg::ADDR_OSC_CTRL, 0, 0);
        `CHK("rsvd_kept", ctl(1'b0, 3'h7, 1'b1, 2'h3), rd)
        per(80);
        // enabled secondary: pause length, clock held low
        apb(1, clock_select_pkg::ADDR_TMR1_CTRL, 32'h0000_0008, 4'h1);
        apb(1, clock_select_pkg::ADDR_OSC_CTRL, ctl(1'b0, 3'h7, 1'b0, 2'h1), 4'h1);
        n = 0;
        while (clk_switching !== 1'b1 && n < 50) begin @(posedge pclk); n++; end
        t0 = $time;
        low_ok = 1'b1;
        while (clk_switching === 1'b1 && n < 2000) begin
            if (device_clk !== 1'b0) low_ok = 1'b0;
            @(posedge pclk); n++;
        end
        t = $time - t0;
        `CHK("pause_low", 1'b1, low_ok)
        `CHK("pause_len", 1'b1, (t >= 560 && t <= 1260))
        per(200);
        // digital mode allows the secondary without its enable
        apb(1, clock_select_pkg::ADDR_TMR1_CTRL, 32'h0000_0000, 4'h1);
        apb(1, clock_select_pkg::ADDR_OSC_CTRL, ctl(1'b0, 3'h7, 1'b0, 2'h3), 4'h1);
        per(80);
        apb(1, clock_select_pkg::ADDR_CFG, 32'h0000_0021, 4'h1);
        apb(1, clock_select_pkg::ADDR_OSC_CTRL, ctl(1'b0, 3'h7, 1'b0, 2'h1), 4'h1);
        apb(0, clock_select_pkg::ADDR_OSC_CTRL, 0, 0);
        `CHK("sec_digital", ctl(1'b0, 3'h7, 1'b1, 2'h1), rd)
        per(200);
        stop_test();
    end
endmodule : tb

// File: hdl/clock_select_pkg.sv
package clock_select_pkg;
    // register indices; byte address is four times the index
    localparam logic [15:0] IDX_OSC_CTRL   = 16'h0fd3;
    localparam logic [15:0] IDX_OSC_TUNE   = 16'h0fd4;
    localparam logic [15:0] IDX_TMR1_CTRL  = 16'h0fd5;
    localparam logic [15:0] IDX_CFG        = 16'h0fd6;
    localparam logic [15:0] ADDR_OSC_CTRL  = IDX_OSC_CTRL << 2;
    localparam logic [15:0] ADDR_OSC_TUNE  = IDX_OSC_TUNE << 2;
    localparam logic [15:0] ADDR_TMR1_CTRL = IDX_TMR1_CTRL << 2;
    localparam logic [15:0] ADDR_CFG       = IDX_CFG << 2;

    // oscillator_control_reg field positions
    localparam int unsigned POS_IDLE   = 7;
    localparam int unsigned POS_IFS    = 4;
    localparam int unsigned POS_STARTUP_TIMER_DONE   = 3;
    localparam int unsigned POS_UNIMP  = 2;
    localparam int unsigned POS_SCS    = 0;
    // own registers
    localparam int unsigned POS_LFS    = 7;
    localparam int unsigned POS_SEC_EN = 3;
    localparam int unsigned POS_SECM   = 0;
    localparam int unsigned POS_PCFG   = 2;
    localparam int unsigned POS_TWOSPD = 5;

    // values after reset
    localparam logic       IDLE_RST   = 1'b0;
    localparam logic [2:0] IFS_RST    = 3'h6;
    localparam logic [1:0] SCS_RST    = 2'h0;
    localparam logic       LFS_RST    = 1'b0;
    localparam logic       SEC_EN_RST = 1'b0;
    localparam logic [1:0] SECM_RST   = 2'h0;
    localparam logic [2:0] PCFG_RST   = 3'h0;
    localparam logic       TWOSPD_RST = 1'b1;

    // encodings
    localparam logic [2:0] IFS_DIRECT   = 3'h7;
    localparam logic [2:0] IFS_LOWFREQ  = 3'h0;
    localparam logic [1:0] SRC_PRIMARY  = 2'h0;
    localparam logic [1:0] SRC_SECOND   = 2'h1;
    localparam logic [1:0] SRC_RESERVED = 2'h2;
    localparam logic [1:0] SRC_INTERNAL = 2'h3;
    localparam logic [1:0] SECM_DIGITAL = 2'h1;
    localparam logic [2:0] PCFG_INT_A   = 3'h0;
    localparam logic [2:0] PCFG_INT_B   = 3'h1;

    // switch pause in rising edges of each source; counting starts at an
    // arbitrary phase, so one extra edge is needed to cover whole cycles
    // (three old edges give two full cycles, four new edges three to four)
    localparam logic [2:0] OLD_EDGES = 3'h3;
    localparam logic [2:0] NEW_EDGES = 3'h4;

    // synchroniser lanes
    localparam int unsigned LN_PRIM = 0;
    localparam int unsigned LN_SEC  = 1;
    localparam int unsigned LN_FAST = 2;
    localparam int unsigned LN_SLOW = 3;
    localparam int unsigned LN_OST  = 4;

    typedef enum logic [1:0] {SW_RUN, SW_OLD, SW_NEW} sw_state_t;
endpackage : clock_select_pkg

// File: hdl/system_clock_select_control.sv
// The APB slave port was left to the implementer.
`timescale 1ns/1ns
// Functional notes
// - power-down request enters idle when idle select is 1, else sleep
// - frequency field picks internal postscaler ratio, 111 direct down to 000 slow
// - at 000 low clock is fast oscillator over 256 or slow rc
// - startup done bit follows start-up timer expiry with two-speed start-up, else always reads 1
// - startup done resets to 0 with two-speed start-up, 1 without
// - control register bit 2 always reads 1
// - select 11 internal, 10 reserved, 01 secondary, 00 primary clock
// - primary is internal postscaler for config 000/001, else primary clock input
// - secondary select ignored unless its enable set or digital mode
// - switch pauses two old cycles plus three new cycles, glitch free
// - reset clears idle select and source select, frequency field to 110
module system_clock_select_control (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [15:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        primary_clk_in,
    input  wire logic        secondary_clk_in,
    input  wire logic        fast_osc_in,
    input  wire logic        slow_rc_in,
    input  wire logic        ost_expired_in,
    input  wire logic        power_down_req,
    output logic             enter_idle,
    output logic             enter_sleep,
    output logic             device_clk,
    output logic             clk_switching
);
    typedef struct packed {
        logic                          idle_sel;
        logic [2:0]                    ifs;
        logic [1:0]                    scs;
        logic                          lfs;
        logic                          sec_en;
        logic [1:0]                    sec_mode;
        logic [2:0]                    prim_cfg;
        logic                          two_speed;
        logic [4:0]                    s1;
        logic [4:0]                    s2;
        logic [4:0]                    s3;
        logic [4:0]                    filt;
        logic [7:0]                    post_cnt;
        clock_select_pkg::sw_state_t   sw;
        logic [1:0]                    cur_src;
        logic [1:0]                    new_src;
        logic [1:0]                    edge_cnt;
        logic                          clk_out;
        logic [31:0]                   rdata;
        logic                          idle_p;
        logic                          sleep_p;
    } state_t;

    localparam state_t ST_RST = '{
        idle_sel:  clock_select_pkg::IDLE_RST,
        ifs:       clock_select_pkg::IFS_RST,
        scs:       clock_select_pkg::SCS_RST,
        lfs:       clock_select_pkg::LFS_RST,
        sec_en:    clock_select_pkg::SEC_EN_RST,
        sec_mode:  clock_select_pkg::SECM_RST,
        prim_cfg:  clock_select_pkg::PCFG_RST,
        two_speed: clock_select_pkg::TWOSPD_RST,
        sw:        clock_select_pkg::SW_RUN,
        cur_src:   clock_select_pkg::SCS_RST,
        new_src:   clock_select_pkg::SCS_RST,
        default:   '0
    };

    state_t st;
    state_t nx;

    // internal postscaler output level
    function automatic logic post_level(input logic [2:0] ifs, input logic lfs,
                                        input logic [4:0] filt, input logic [7:0] cnt);
        logic lvl;
        lvl = 1'b0;
        if (ifs == clock_select_pkg::IFS_DIRECT) begin
            lvl = filt[clock_select_pkg::LN_FAST];
        end else if (ifs == clock_select_pkg::IFS_LOWFREQ) begin
            lvl = lfs ? cnt[7] : filt[clock_select_pkg::LN_SLOW];
        end else begin
            lvl = cnt[3'(3'd6 - ifs)];
        end
        return lvl;
    endfunction : post_level

    // level of a source as seen by the selector
    function automatic logic src_level(input logic [1:0] src, input logic [2:0] pcfg,
                                       input logic [4:0] filt, input logic post);
        logic lvl;
        lvl = 1'b0;
        case (src)
            clock_select_pkg::SRC_INTERNAL: lvl = post;
            clock_select_pkg::SRC_SECOND:   lvl = filt[clock_select_pkg::LN_SEC];
            clock_select_pkg::SRC_PRIMARY: begin
                if (pcfg == clock_select_pkg::PCFG_INT_A ||
                    pcfg == clock_select_pkg::PCFG_INT_B) begin
                    lvl = post;
                end else begin
                    lvl = filt[clock_select_pkg::LN_PRIM];
                end
            end
            default: lvl = 1'b0;
        endcase
        return lvl;
    endfunction : src_level

    logic        acc_wr;
    logic        mapped;
    logic        startup_timer_done;
    logic        sec_ok;
    logic        post_now;
    logic        post_nx;
    logic        lvl_old_now;
    logic        lvl_old_nx;
    logic        lvl_new_now;
    logic        lvl_new_nx;
    logic [4:0]  pins;
    logic [1:0]  wr_scs;

    assign pins = {ost_expired_in, slow_rc_in, fast_osc_in, secondary_clk_in, primary_clk_in};

    // address decode and status bits
    assign mapped = (paddr == clock_select_pkg::ADDR_OSC_CTRL) ||
                    (paddr == clock_select_pkg::ADDR_OSC_TUNE) ||
                    (paddr == clock_select_pkg::ADDR_TMR1_CTRL) ||
                    (paddr == clock_select_pkg::ADDR_CFG);
    assign acc_wr = psel && penable && pwrite && pstrb[0] && mapped;
    assign startup_timer_done   = st.two_speed ? st.filt[clock_select_pkg::LN_OST] : 1'b1;
    assign sec_ok = st.sec_en || (st.sec_mode == clock_select_pkg::SECM_DIGITAL);
    assign wr_scs = pwdata[clock_select_pkg::POS_SCS +: 2];

    // next state of the whole block
    always_comb begin
        nx = st;
        // three-flop synchronisers; a change counts once stages two and three agree
        nx.s1   = pins;
        nx.s2   = st.s1;
        nx.s3   = st.s2;
        nx.filt = (st.s2 & st.s3) | (st.filt & (st.s2 | st.s3));
        // postscaler counts rising edges of the fast oscillator
        if (nx.filt[clock_select_pkg::LN_FAST] && !st.filt[clock_select_pkg::LN_FAST]) begin
            nx.post_cnt = 8'(st.post_cnt + 8'h01);
        end
        // register writes, low byte lane only
        if (acc_wr && paddr == clock_select_pkg::ADDR_OSC_CTRL) begin
            nx.idle_sel = pwdata[clock_select_pkg::POS_IDLE];
            nx.ifs      = pwdata[clock_select_pkg::POS_IFS +: 3];
            if (wr_scs == clock_select_pkg::SRC_RESERVED) begin
                nx.scs = st.scs;
            end else if (wr_scs == clock_select_pkg::SRC_SECOND && !sec_ok) begin
                nx.scs = st.scs;
            end else begin
                nx.scs = wr_scs;
            end
        end
        if (acc_wr && paddr == clock_select_pkg::ADDR_OSC_TUNE) begin
            nx.lfs = pwdata[clock_select_pkg::POS_LFS];
        end
        if (acc_wr && paddr == clock_select_pkg::ADDR_TMR1_CTRL) begin
            nx.sec_en = pwdata[clock_select_pkg::POS_SEC_EN];
        end
        if (acc_wr && paddr == clock_select_pkg::ADDR_CFG) begin
            nx.sec_mode  = pwdata[clock_select_pkg::POS_SECM +: 2];
            nx.prim_cfg  = pwdata[clock_select_pkg::POS_PCFG +: 3];
            nx.two_speed = pwdata[clock_select_pkg::POS_TWOSPD];
        end
        // read data captured in the setup cycle so prdata comes from a flop
        if (psel && !penable) begin
            nx.rdata = 32'h0000_0000;
            if (paddr == clock_select_pkg::ADDR_OSC_CTRL) begin
                nx.rdata[clock_select_pkg::POS_IDLE]     = st.idle_sel;
                nx.rdata[clock_select_pkg::POS_IFS +: 3] = st.ifs;
                nx.rdata[clock_select_pkg::POS_STARTUP_TIMER_DONE]     = startup_timer_done;
                nx.rdata[clock_select_pkg::POS_UNIMP]    = 1'b1;
                nx.rdata[clock_select_pkg::POS_SCS +: 2] = st.scs;
            end else if (paddr == clock_select_pkg::ADDR_OSC_TUNE) begin
                nx.rdata[clock_select_pkg::POS_LFS] = st.lfs;
            end else if (paddr == clock_select_pkg::ADDR_TMR1_CTRL) begin
                nx.rdata[clock_select_pkg::POS_SEC_EN] = st.sec_en;
            end else if (paddr == clock_select_pkg::ADDR_CFG) begin
                nx.rdata[clock_select_pkg::POS_SECM +: 2] = st.sec_mode;
                nx.rdata[clock_select_pkg::POS_PCFG +: 3] = st.prim_cfg;
                nx.rdata[clock_select_pkg::POS_TWOSPD]    = st.two_speed;
            end
        end
        // power-down instruction picks idle or sleep
        nx.idle_p  = power_down_req && st.idle_sel;
        nx.sleep_p = power_down_req && !st.idle_sel;
        // levels before and after this edge, for edge counting
        post_now    = post_level(st.ifs, st.lfs, st.filt, st.post_cnt);
        post_nx     = post_level(nx.ifs, nx.lfs, nx.filt, nx.post_cnt);
        lvl_old_now = src_level(st.cur_src, st.prim_cfg, st.filt, post_now);
        lvl_old_nx  = src_level(st.cur_src, nx.prim_cfg, nx.filt, post_nx);
        lvl_new_now = src_level(st.new_src, st.prim_cfg, st.filt, post_now);
        lvl_new_nx  = src_level(st.new_src, nx.prim_cfg, nx.filt, post_nx);
        // switch sequencer; the old clock is only cut while it is low
        case (st.sw)
            clock_select_pkg::SW_RUN: begin
                if (st.scs != st.cur_src && !lvl_old_nx) begin
                    nx.sw       = clock_select_pkg::SW_OLD;
                    nx.new_src  = st.scs;
                    nx.edge_cnt = 2'h0;
                end
            end
            clock_select_pkg::SW_OLD: begin
                if (lvl_old_nx && !lvl_old_now) begin
                    if (st.edge_cnt == 2'(clock_select_pkg::OLD_EDGES - 2'h1)) begin
                        nx.sw       = clock_select_pkg::SW_NEW;
                        nx.cur_src  = st.new_src;
                        nx.edge_cnt = 2'h0;
                    end else begin
                        nx.edge_cnt = 2'(st.edge_cnt + 2'h1);
                    end
                end
            end
            clock_select_pkg::SW_NEW: begin
                if (lvl_new_nx && !lvl_new_now) begin
                    if (st.edge_cnt == 2'(clock_select_pkg::NEW_EDGES - 2'h1)) begin
                        nx.sw       = clock_select_pkg::SW_RUN;
                        nx.edge_cnt = 2'h0;
                    end else begin
                        nx.edge_cnt = 2'(st.edge_cnt + 2'h1);
                    end
                end
            end
            default: nx.sw = clock_select_pkg::SW_RUN;
        endcase
        // output clock follows the current source only when running
        nx.clk_out = (nx.sw == clock_select_pkg::SW_RUN) &&
                     src_level(nx.cur_src, nx.prim_cfg, nx.filt, post_nx);
    end

    // single state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= ST_RST;
        end else begin
            st <= nx;
        end
    end

    // zero wait states; unmapped addresses answer with an error
    assign pready        = 1'b1;
    assign pslverr       = psel && penable && !mapped;
    assign prdata        = st.rdata;
    assign enter_idle    = st.idle_p;
    assign enter_sleep   = st.sleep_p;
    assign device_clk    = st.clk_out;
    assign clk_switching = (st.sw != clock_select_pkg::SW_RUN);

    // checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    AST_IDLE_ENTRY: assert property (power_down_req && st.idle_sel |=> enter_idle && !enter_sleep)
        else $error("idle not entered");
    AST_SLEEP_ENTRY: assert property (power_down_req && !st.idle_sel |=> enter_sleep && !enter_idle)
        else $error("sleep not entered");
    AST_POST_COUNT: assert property (!st.filt[clock_select_pkg::LN_FAST] && nx.filt[clock_select_pkg::LN_FAST] |=> st.post_cnt == 8'($past(st.post_cnt) + 8'h01))
        else $error("postscaler missed an edge");
    AST_LOWFREQ_SRC: assert property (st.ifs == clock_select_pkg::IFS_LOWFREQ && !st.lfs |-> post_level(st.ifs, st.lfs, st.filt, st.post_cnt) == st.filt[clock_select_pkg::LN_SLOW])
        else $error("slow rc not used at low frequency");
    AST_STARTUP_TIMER_DONE_READ: assert property (psel && !penable && !pwrite && paddr == clock_select_pkg::ADDR_OSC_CTRL |=> prdata[clock_select_pkg::POS_STARTUP_TIMER_DONE] == (!$past(st.two_speed) || $past(st.filt[clock_select_pkg::LN_OST])) && prdata[clock_select_pkg::POS_UNIMP])
        else $error("status read wrong");
    AST_SEC_IGNORED: assert property (acc_wr && paddr == clock_select_pkg::ADDR_OSC_CTRL && wr_scs == clock_select_pkg::SRC_SECOND && !sec_ok |=> st.scs == $past(st.scs))
        else $error("secondary select not ignored");
    AST_RESERVED_KEEP: assert property (acc_wr && paddr == clock_select_pkg::ADDR_OSC_CTRL && wr_scs == clock_select_pkg::SRC_RESERVED |=> st.scs == $past(st.scs))
        else $error("reserved select changed source");
    AST_HOLD_LOW: assert property (st.sw != clock_select_pkg::SW_RUN |-> !device_clk && clk_switching)
        else $error("clock not held low in pause");
    AST_OLD_COUNT: assert property (st.sw == clock_select_pkg::SW_OLD ##1 st.sw == clock_select_pkg::SW_NEW |-> $past(st.edge_cnt) == 2'(clock_select_pkg::OLD_EDGES - 2'h1))
        else $error("old source count wrong");
    AST_NEW_COUNT: assert property (st.sw == clock_select_pkg::SW_NEW ##1 st.sw == clock_select_pkg::SW_RUN |-> $past(st.edge_cnt) == 2'(clock_select_pkg::NEW_EDGES - 2'h1) && st.cur_src == $past(st.new_src))
        else $error("new source count wrong");

    COV_SWITCH_INT: cover property (st.sw == clock_select_pkg::SW_NEW && st.cur_src == clock_select_pkg::SRC_INTERNAL ##1 st.sw == clock_select_pkg::SW_RUN);
    COV_SWITCH_SEC: cover property (st.sw == clock_select_pkg::SW_NEW && st.cur_src == clock_select_pkg::SRC_SECOND ##1 st.sw == clock_select_pkg::SW_RUN);
    COV_IDLE: cover property (enter_idle);
    COV_SLVERR: cover property (pslverr);
endmodule : system_clock_select_control
